// ===== bench/sdadc_host_model.sv
`timescale 1ns/1ns

module sdadc_host_model (
  // Clock
  input  wire logic       ref_clk_i,
  // Extended SFR port
  output logic [7:0]      sfr_addr_o,
  output logic [7:0]      sfr_wdata_o,
  output logic            sfr_wr_o,
  output logic            sfr_rd_o,
  input  wire logic [7:0] sfr_rdata_i
);
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wdata_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
  end

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // extended port access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    sfr_addr_o = a;
    sfr_wdata_o = d;
    sfr_wr_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    sfr_wr_o = 1'b0;
    sfr_wdata_o = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    sfr_addr_o = a;
    sfr_rd_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    d = sfr_rdata_i;
    sfr_rd_o = 1'b0;
    sfr_addr_o = ~a;
  endtask
endmodule

// ===== bench/sigma_delta_adc_control_tb.sv
`timescale 1ns/1ns
`include "sdadc_defines.svh"

module sigma_delta_adc_control_tb;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] rb;
    logic [5:0] o;
  } sdadc_tb_row_t;

  logic                   ref_clk_i;
  logic                   nrst_i;
  logic [7:0]             sfr_addr;
  logic [7:0]             sfr_wdata;
  logic                   sfr_wr;
  logic                   sfr_rd;
  logic [7:0]             sfr_rdata;
  logic                   sample_valid;
  logic [1:0]             sample_chan;
  logic [23:0]            sample_data;
  logic                   power_on;
  logic                   conv_en;
  logic                   wiring;
  logic                   bg_on;
  logic                   ref_oe_n;
  logic                   gain_sel;
  sdadc_pkg::sdadc_role_t roles [4];
  logic                   irq;
  int                     num_errors;
  int                     num_checks;
  int                     cyc;
  logic [23:0]            v;
  logic [7:0]             b;
  sdadc_tb_row_t          rows [12];

  sdadc_ctrl #(.CHANNELS(4)) uut (
    .ref_clk_i               (ref_clk_i),
    .nrst_i                  (nrst_i),
    .sfr_addr_i              (sfr_addr),
    .sfr_wdata_i             (sfr_wdata),
    .sfr_wr_i                (sfr_wr),
    .sfr_rd_i                (sfr_rd),
    .sfr_rdata_o             (sfr_rdata),
    .sample_valid_i          (sample_valid),
    .sample_chan_i           (sample_chan),
    .sample_data_i           (sample_data),
    .converter_power_on_o    (power_on),
    .conversion_enable_o     (conv_en),
    .wiring_mode_select_o    (wiring),
    .bandgap_reference_on_o  (bg_on),
    .reference_io_pin_oe_n_o (ref_oe_n),
    .channel_gain_select_o   (gain_sel),
    .pair_role_o             (roles),
    .conversion_end_irq_o    (irq)
  );

  sdadc_host_model host (
    .ref_clk_i   (ref_clk_i),
    .sfr_addr_o  (sfr_addr),
    .sfr_wdata_o (sfr_wdata),
    .sfr_wr_o    (sfr_wr),
    .sfr_rd_o    (sfr_rd),
    .sfr_rdata_i (sfr_rdata)
  );

  initial ref_clk_i = 1'b0;
  always #2 ref_clk_i = ~ref_clk_i;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_outs(input logic [5:0] o);
    chk(24'({power_on, conv_en, wiring, bg_on, ref_oe_n, gain_sel}), 24'(o), "mode outputs");
    chk(24'(roles[0]), 24'(sdadc_pkg::SDADC_ROLE_VOLT1), "role pair0");
    chk(24'(roles[1]), 24'(sdadc_pkg::SDADC_ROLE_CUR1), "role pair1");
    chk(24'(roles[2]), o[3] ? 24'(sdadc_pkg::SDADC_ROLE_VOLT2) : 24'(sdadc_pkg::SDADC_ROLE_CUR2), "role pair2");
    chk(24'(roles[3]), o[3] ? 24'(sdadc_pkg::SDADC_ROLE_CUR2) : 24'(sdadc_pkg::SDADC_ROLE_UNUSED), "role pair3");
  endtask

  task automatic rd_res(input int ch, output logic [23:0] r);
    logic [7:0] x;
    for (int i = 0; i < 3; i++) begin
      host.rd(`SDADC_OFS_RES_BASE + 8'(4 * ch + i), x);
      r[8*i +: 8] = x;
    end
  endtask

  task automatic put(input logic [1:0] ch, input logic [23:0] d);
    @(posedge ref_clk_i);
    #1;
    sample_valid = 1'b1;
    sample_chan = ch;
    sample_data = d;
  endtask

  task automatic idle();
    @(posedge ref_clk_i);
    #1;
    sample_valid = 1'b0;
    sample_data = ~sample_data;
  endtask

  task automatic wait_irq(input int n);
    int seen;
    seen = 0;
    repeat (5) begin
      @(posedge ref_clk_i);
      #1;
      if (irq === 1'b1) seen++;
    end
    chk(24'(seen), 24'(n), "irq pulses");
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    num_errors = 0;
    num_checks = 0;
    cyc = 0;
    nrst_i = 1'b0;
    sample_valid = 1'b0;
    sample_chan = 2'h0;
    sample_data = 24'h000000;
    rows[0] = '{8'hA3, 8'h80, 8'h80, 6'b100100};
    rows[1] = '{8'hA3, 8'h40, 8'h40, 6'b010100};
    rows[2] = '{8'hA3, 8'h20, 8'h20, 6'b001100};
    rows[3] = '{8'hA3, 8'h08, 8'h08, 6'b000010};
    rows[4] = '{8'hA3, 8'h04, 8'h04, 6'b000101};
    rows[5] = '{8'hA3, 8'h13, 8'h00, 6'b000100};
    rows[6] = '{8'hA3, 8'hFF, 8'hEC, 6'b111011};
    rows[7] = '{8'hA3, 8'h00, 8'h00, 6'b000100};
    rows[8] = '{8'hA5, 8'hFF, 8'h0F, 6'b000100};
    rows[9] = '{8'hA6, 8'hA5, 8'h05, 6'b000100};
    rows[10] = '{8'hA4, 8'h55, 8'h00, 6'b000100};
    rows[11] = '{8'hB0, 8'hAA, 8'h00, 6'b000100};
    repeat (5) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    chk_outs(6'b000100);
    // Register rows: write, read back, check front-end controls on mode register rows
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, b);
      chk(24'(b), 24'(rows[i].rb), "readback");
      if (rows[i].a == `SDADC_OFS_MODE) chk_outs(rows[i].o);
    end
    $display("register rows done");
    // Mid-run reset clears mode and filter registers
    host.wr(`SDADC_OFS_MODE, 8'hAC);
    @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    chk_outs(6'b000100);
    host.rd(`SDADC_OFS_MODE, b);
    chk(24'(b), 24'h000000, "mode after reset");
    host.rd(`SDADC_OFS_INSERT, b);
    chk(24'(b), 24'h000000, "insert after reset");
    host.rd(`SDADC_OFS_DELAY, b);
    chk(24'(b), 24'h000000, "delay after reset");
    $display("reset test done");
    // Two-wire round with bypass and clamping
    host.wr(`SDADC_OFS_INSERT, 8'h0F);
    host.wr(`SDADC_OFS_MODE, 8'hC0);
    put(2'd0, 24'h123456);
    put(2'd1, 24'h7FFFFF);
    idle();
    wait_irq(0);
    put(2'd2, 24'h800000);
    idle();
    wait_irq(1);
    rd_res(0, v);
    chk(v, 24'h123456, "result ch0");
    rd_res(1, v);
    chk(v, 24'h400000, "result ch1 clamp");
    rd_res(2, v);
    chk(v, 24'hC00000, "result ch2 clamp");
    host.rd(8'hC3, b);
    chk(24'(b), 24'h000000, "pad byte");
    $display("two-wire test done");
    // Three-wire round needs channel 3
    host.wr(`SDADC_OFS_MODE, 8'hE0);
    put(2'd0, `SDADC_FS_POS);
    put(2'd1, 24'h000020);
    put(2'd2, 24'h000030);
    idle();
    wait_irq(0);
    put(2'd3, 24'hFFFFFE);
    idle();
    wait_irq(1);
    rd_res(3, v);
    chk(v, 24'hFFFFFE, "result ch3");
    rd_res(0, v);
    chk(v, 24'h400000, "full scale ch0");
    $display("three-wire test done");
    // Stopping conversion clears results and drops samples
    host.wr(`SDADC_OFS_MODE, 8'h80);
    rd_res(0, v);
    chk(v, 24'h000000, "cleared by stop");
    put(2'd0, 24'h111111);
    idle();
    host.wr(`SDADC_OFS_MODE, 8'h40);
    put(2'd1, 24'h222222);
    put(2'd0, 24'h111111);
    idle();
    host.wr(`SDADC_OFS_MODE, 8'hC0);
    rd_res(0, v);
    chk(v, 24'h000000, "dropped power only");
    rd_res(1, v);
    chk(v, 24'h000000, "dropped enable only");
    $display("stop test done");
    // Filter inserted, delay honoured only when filtering
    host.wr(`SDADC_OFS_MODE, 8'h00);
    host.wr(`SDADC_OFS_INSERT, 8'h0A);
    host.wr(`SDADC_OFS_DELAY, 8'h06);
    host.wr(`SDADC_OFS_MODE, 8'hC0);
    put(2'd0, 24'h100000);
    put(2'd1, 24'h020000);
    put(2'd2, 24'h030000);
    idle();
    wait_irq(1);
    rd_res(0, v);
    chk(v, 24'h100000, "filtered first sample");
    rd_res(1, v);
    chk(v, 24'h020000, "bypass ignores delay");
    rd_res(2, v);
    chk(v, 24'h000000, "delayed first sample");
    $display("filter test done");
    close_out();
  end
endmodule

// ===== rtl/sdadc_ctrl.sv
`timescale 1ns/1ns
`include "sdadc_defines.svh"


module sdadc_ctrl #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   nrst_i,
  // Extended SFR port
  input  wire logic [7:0]             sfr_addr_i,
  input  wire logic [7:0]             sfr_wdata_i,
  input  wire logic                   sfr_wr_i,
  input  wire logic                   sfr_rd_i,
  output logic [7:0]                  sfr_rdata_o,
  // Samples from the decimation filter
  input  wire logic                   sample_valid_i,
  input  wire logic [1:0]             sample_chan_i,
  input  wire logic [23:0]            sample_data_i,
  // Analog front-end control
  output logic                        converter_power_on_o,
  output logic                        conversion_enable_o,
  output logic                        wiring_mode_select_o,
  output logic                        bandgap_reference_on_o,
  output logic                        reference_io_pin_oe_n_o,
  output logic                        channel_gain_select_o,
  output sdadc_pkg::sdadc_role_t      pair_role_o [4],
  // Events
  output logic                        conversion_end_irq_o
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]             adc_mode_control;
  logic [7:0]             hpf_insert_control;
  logic [7:0]             hpf_delay_control;
  sdadc_pkg::sdadc_code_t conversion_result [4];
  logic [7:0]             next_mode;
  logic [7:0]             next_rdata;
  logic [3:0]             round_mask;
  logic [3:0]             active_mask;
  logic [3:0]             next_mask;
  logic                   running;
  logic                   store_en;
  logic                   round_done;
  logic [1:0]             res_ch;
  logic [1:0]             res_byte;
  sdadc_pkg::sdadc_role_t next_role [4];

  sdadc_smp_if smp ();

  // ----------------------------------------
  // Mode register write decode
  // ----------------------------------------
  always_comb begin
    next_mode = adc_mode_control;
    if (sfr_wr_i && sfr_addr_i == `SDADC_OFS_MODE) begin
      next_mode = sfr_wdata_i & `SDADC_MODE_MASK;
      // three-channel part has no three-wire mode
      if (CHANNELS < 4) begin
        next_mode[`SDADC_BIT_WIRING] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      adc_mode_control <= `SDADC_RST_REG;
    end else begin
      adc_mode_control <= next_mode;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hpf_insert_control <= `SDADC_RST_REG;
      hpf_delay_control  <= `SDADC_RST_REG;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == `SDADC_OFS_INSERT) begin
        hpf_insert_control <= sfr_wdata_i & `SDADC_CHAN_MASK;
      end
      if (sfr_addr_i == `SDADC_OFS_DELAY) begin
        hpf_delay_control <= sfr_wdata_i & `SDADC_CHAN_MASK;
      end
    end
  end

  // ----------------------------------------
  // Analog control outputs
  // ----------------------------------------
  always_comb begin
    if (!next_mode[`SDADC_BIT_WIRING]) begin
      next_role[0] = sdadc_pkg::SDADC_ROLE_VOLT1;
      next_role[1] = sdadc_pkg::SDADC_ROLE_CUR1;
      next_role[2] = sdadc_pkg::SDADC_ROLE_CUR2;
      next_role[3] = sdadc_pkg::SDADC_ROLE_UNUSED;
    end else begin
      next_role[0] = sdadc_pkg::SDADC_ROLE_VOLT1;
      next_role[1] = sdadc_pkg::SDADC_ROLE_CUR1;
      next_role[2] = sdadc_pkg::SDADC_ROLE_VOLT2;
      next_role[3] = sdadc_pkg::SDADC_ROLE_CUR2;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      converter_power_on_o    <= 1'b0;
      conversion_enable_o     <= 1'b0;
      wiring_mode_select_o    <= 1'b0;
      bandgap_reference_on_o  <= 1'b1;
      reference_io_pin_oe_n_o <= 1'b0;
      channel_gain_select_o   <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        pair_role_o[i] <= sdadc_pkg::SDADC_ROLE_VOLT1;
      end
      pair_role_o[1] <= sdadc_pkg::SDADC_ROLE_CUR1;
      pair_role_o[2] <= sdadc_pkg::SDADC_ROLE_CUR2;
      pair_role_o[3] <= sdadc_pkg::SDADC_ROLE_UNUSED;
    end else begin
      converter_power_on_o    <= next_mode[`SDADC_BIT_POWER];
      conversion_enable_o     <= next_mode[`SDADC_BIT_CONV];
      wiring_mode_select_o    <= next_mode[`SDADC_BIT_WIRING];
      bandgap_reference_on_o  <= !next_mode[`SDADC_BIT_REFCUT];
      reference_io_pin_oe_n_o <= next_mode[`SDADC_BIT_REFCUT];
      channel_gain_select_o   <= next_mode[`SDADC_BIT_GAIN];
      for (int i = 0; i < 4; i++) begin
        pair_role_o[i] <= next_role[i];
      end
    end
  end

  // ----------------------------------------
  // Sample path into the high-pass filter
  // ----------------------------------------
  // run only with power and enable
  assign running    = adc_mode_control[`SDADC_BIT_POWER] && adc_mode_control[`SDADC_BIT_CONV];
  assign smp.clr    = !adc_mode_control[`SDADC_BIT_CONV];
  assign smp.in_vld = sample_valid_i && running && (32'(sample_chan_i) < CHANNELS);
  assign smp.in_ch  = sample_chan_i;
  assign smp.in_dat = sample_data_i;
  assign smp.bypass = hpf_insert_control[3:0];
  assign smp.delay  = hpf_delay_control[3:0];

  sdadc_hpf u_hpf (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .hp        (smp)
  );

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  assign store_en = smp.out_vld && running;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 4; i++) begin
        conversion_result[i] <= `SDADC_RST_RES;
      end
    end else if (!adc_mode_control[`SDADC_BIT_CONV]) begin
      for (int i = 0; i < 4; i++) begin
        conversion_result[i] <= `SDADC_RST_RES;
      end
    end else if (store_en) begin
      conversion_result[smp.out_ch] <= smp.out_dat;
    end
  end

  // ----------------------------------------
  // Round tracking and conversion-end request
  // ----------------------------------------
  always_comb begin
    if (CHANNELS < 4 || !adc_mode_control[`SDADC_BIT_WIRING]) begin
      active_mask = 4'h7;
    end else begin
      active_mask = 4'hF;
    end
    next_mask = round_mask;
    if (store_en) begin
      next_mask[smp.out_ch] = 1'b1;
    end
    round_done = store_en && ((next_mask & active_mask) == active_mask);
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      round_mask           <= 4'h0;
      conversion_end_irq_o <= 1'b0;
    end else begin
      conversion_end_irq_o <= round_done;
      if (!running || round_done) begin
        round_mask <= 4'h0;
      end else begin
        round_mask <= next_mask;
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  assign res_ch   = sfr_addr_i[3:2];
  assign res_byte = sfr_addr_i[1:0];

  always_comb begin
    next_rdata = 8'h00;
    if (sfr_addr_i == `SDADC_OFS_MODE) begin
      next_rdata = adc_mode_control;
    end else if (sfr_addr_i == `SDADC_OFS_INSERT) begin
      next_rdata = hpf_insert_control;
    end else if (sfr_addr_i == `SDADC_OFS_DELAY) begin
      next_rdata = hpf_delay_control;
    end else if (sfr_addr_i >= `SDADC_OFS_RES_BASE && sfr_addr_i <= `SDADC_OFS_RES_LAST
                 && 32'(res_ch) < CHANNELS) begin
      case (res_byte)
        2'h0:    next_rdata = conversion_result[res_ch][7:0];
        2'h1:    next_rdata = conversion_result[res_ch][15:8];
        2'h2:    next_rdata = conversion_result[res_ch][23:16];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  power_write_a: assert property (sfr_wr_i && sfr_addr_i == `SDADC_OFS_MODE
    |=> converter_power_on_o == $past(sfr_wdata_i[7]))
    else $error("power output does not follow mode write");
  conv_write_a: assert property (sfr_wr_i && sfr_addr_i == `SDADC_OFS_MODE
    |=> conversion_enable_o == $past(sfr_wdata_i[6]) && adc_mode_control[1:0] == 2'h0)
    else $error("conversion output does not follow mode write");
  two_wire_a: assert property (!wiring_mode_select_o |-> pair_role_o[3] == sdadc_pkg::SDADC_ROLE_UNUSED
    && pair_role_o[2] == sdadc_pkg::SDADC_ROLE_CUR2)
    else $error("two-wire pair roles wrong");
  three_wire_a: assert property (wiring_mode_select_o |-> pair_role_o[2] == sdadc_pkg::SDADC_ROLE_VOLT2
    && pair_role_o[3] == sdadc_pkg::SDADC_ROLE_CUR2)
    else $error("three-wire pair roles wrong");
  ref_dir_a: assert property (reference_io_pin_oe_n_o == !bandgap_reference_on_o
    && reference_io_pin_oe_n_o == adc_mode_control[`SDADC_BIT_REFCUT])
    else $error("reference direction disagrees with band-gap state");
  gain_write_a: assert property (sfr_wr_i && sfr_addr_i == `SDADC_OFS_MODE
    |=> channel_gain_select_o == $past(sfr_wdata_i[2]))
    else $error("gain output does not follow mode write");
  result_clear_a: assert property (!conversion_enable_o |=> conversion_result[0] == 24'h000000
    && conversion_result[1] == 24'h000000 && conversion_result[2] == 24'h000000
    && conversion_result[3] == 24'h000000)
    else $error("result not cleared while stopped");
  run_gate_a: assert property (!running |=> !store_en)
    else $error("result stored while converter not running");
  round_irq_a: assert property (conversion_end_irq_o |-> $past(store_en) ##1 !conversion_end_irq_o)
    else $error("conversion-end request without a completing store");

  irq_cov_c:   cover property (conversion_end_irq_o);
  three_cov_c: cover property (wiring_mode_select_o && conversion_end_irq_o);
  stop_cov_c:  cover property (conversion_enable_o ##1 !conversion_enable_o);

endmodule

// ===== rtl/sdadc_defines.svh
`ifndef SDADC_DEFINES_SVH
`define SDADC_DEFINES_SVH

// ----------------------------------------
// Register offsets in the extended SFR space
// ----------------------------------------
`define SDADC_OFS_MODE     8'hA3
`define SDADC_OFS_INSERT   8'hA5
`define SDADC_OFS_DELAY    8'hA6
// Result bytes: base + 4*channel + byte (0 = low byte)
`define SDADC_OFS_RES_BASE 8'hC0
`define SDADC_OFS_RES_LAST 8'hCF

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define SDADC_BIT_POWER    7
`define SDADC_BIT_CONV     6
`define SDADC_BIT_WIRING   5
`define SDADC_BIT_REFCUT   3
`define SDADC_BIT_GAIN     2
`define SDADC_MODE_MASK    8'hEC
`define SDADC_CHAN_MASK    8'h0F

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define SDADC_RST_REG      8'h00
`define SDADC_RST_RES      24'h000000
`define SDADC_FS_POS       24'h400000
`define SDADC_FS_NEG       24'hC00000
`define SDADC_HPF_SHIFT    4

`endif

// ===== rtl/sdadc_hpf.sv
`timescale 1ns/1ns
`include "sdadc_defines.svh"

module sdadc_hpf (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  // Sample path
  sdadc_smp_if.hpf  hp
);

  sdadc_pkg::sdadc_code_t dc   [4];
  sdadc_pkg::sdadc_code_t prev [4];
  logic signed [24:0]     diff;
  logic signed [24:0]     step;
  sdadc_pkg::sdadc_code_t filt;

  always_comb begin
    diff = $signed({hp.in_dat[23], hp.in_dat}) - $signed({dc[hp.in_ch][23], dc[hp.in_ch]});
    step = diff >>> `SDADC_HPF_SHIFT;
    filt = sdadc_pkg::sdadc_sat(diff);
  end

  // ----------------------------------------
  // DC estimate and previous output per channel
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 4; i++) begin
        dc[i]   <= `SDADC_RST_RES;
        prev[i] <= `SDADC_RST_RES;
      end
    end else if (hp.clr) begin
      for (int i = 0; i < 4; i++) begin
        dc[i]   <= `SDADC_RST_RES;
        prev[i] <= `SDADC_RST_RES;
      end
    end else if (hp.in_vld && !hp.bypass[hp.in_ch]) begin
      dc[hp.in_ch]   <= 24'(dc[hp.in_ch] + step[23:0]);
      prev[hp.in_ch] <= filt;
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hp.out_vld <= 1'b0;
      hp.out_ch  <= 2'h0;
      hp.out_dat <= `SDADC_RST_RES;
    end else begin
      hp.out_vld <= hp.in_vld && !hp.clr;
      hp.out_ch  <= hp.in_ch;
      if (hp.bypass[hp.in_ch]) begin
        hp.out_dat <= sdadc_pkg::sdadc_sat($signed({hp.in_dat[23], hp.in_dat}));
      end else if (hp.delay[hp.in_ch]) begin
        hp.out_dat <= prev[hp.in_ch];
      end else begin
        hp.out_dat <= filt;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  filter_bypass_a: assert property (hp.in_vld && !hp.clr && hp.bypass[hp.in_ch]
    && hp.in_dat == `SDADC_FS_POS |=> hp.out_vld && hp.out_dat == `SDADC_FS_POS)
    else $error("bypassed sample not passed through");
  phase_delay_a: assert property (hp.in_vld && !hp.clr && !hp.bypass[hp.in_ch]
    && hp.delay[hp.in_ch] |=> hp.out_dat == $past(prev[hp.in_ch]))
    else $error("delayed channel did not output previous sample");
  code_range_a: assert property (hp.out_vld |-> ($signed(hp.out_dat) <= $signed(`SDADC_FS_POS))
    && ($signed(hp.out_dat) >= $signed(`SDADC_FS_NEG)))
    else $error("result code outside full scale");
  delay_cov_c: cover property (hp.in_vld && hp.delay[hp.in_ch] && !hp.bypass[hp.in_ch]);

endmodule

// ===== rtl/sdadc_pkg.sv
`include "sdadc_defines.svh"

package sdadc_pkg;

  // Role of an analog input pair
  typedef enum logic [2:0] {
    SDADC_ROLE_UNUSED,
    SDADC_ROLE_VOLT1,
    SDADC_ROLE_CUR1,
    SDADC_ROLE_VOLT2,
    SDADC_ROLE_CUR2
  } sdadc_role_t;

  typedef logic [23:0] sdadc_code_t;

  // Clamp a widened signed value to the full-scale code range
  function automatic sdadc_code_t sdadc_sat(input logic signed [24:0] v);
    logic signed [24:0] pos;
    logic signed [24:0] neg;
    pos = $signed({1'b0, `SDADC_FS_POS});
    neg = $signed({1'b1, `SDADC_FS_NEG});
    if (v > pos) begin
      sdadc_sat = `SDADC_FS_POS;
    end else if (v < neg) begin
      sdadc_sat = `SDADC_FS_NEG;
    end else begin
      sdadc_sat = v[23:0];
    end
  endfunction

endpackage

// ===== rtl/sdadc_smp_if.sv
`timescale 1ns/1ns

interface sdadc_smp_if;
  logic                 clr;
  logic                 in_vld;
  logic [1:0]           in_ch;
  sdadc_pkg::sdadc_code_t in_dat;
  logic [3:0]           bypass;
  logic [3:0]           delay;
  logic                 out_vld;
  logic [1:0]           out_ch;
  sdadc_pkg::sdadc_code_t out_dat;

  modport ctl (output clr, in_vld, in_ch, in_dat, bypass, delay,
               input  out_vld, out_ch, out_dat);
  modport hpf (input  clr, in_vld, in_ch, in_dat, bypass, delay,
               output out_vld, out_ch, out_dat);
endinterface
